// ===== prs_device.sv
// Sequencer device: reset hold, supply enables, battery switch, flags.
`timescale 1ns/1ps
module prs_device #(
  parameter int HOLD_CYC = prs_pkg::RST_HOLD_CYC,
  parameter int STEP_CYC = prs_pkg::HV_STEP_CYC,
  parameter int T2_CYC   = prs_pkg::T2_CYC
) (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst,
  // Link to the processor
  prs_link_if.dev                       link,
  // Supply monitors
  input  wire logic                     rtc_supply_ok,
  input  wire logic                     main_present,
  input  wire logic                     backup_present,
  input  wire logic                     main_above_hi,
  input  wire logic                     main_below_lo,
  input  wire logic                     main_below_fault,
  // Control bits
  input  wire logic                     no_backup_battery,
  input  wire logic                     hv_delay_on,
  input  wire logic                     lv_enable_sw,
  // Regulator settle indications
  input  wire logic [prs_pkg::NDOM-1:0] reg_settled,
  // Supply controls and status
  output logic                          rtc_from_main,
  output logic                          core_io_regulator_en,
  output logic                          hv_other_en,
  output logic                          lv_regulators_en,
  output logic                          early_request
);

  localparam int CW = prs_pkg::CNT_W;
  localparam logic [CW-1:0] HOLD_LIM = CW'(HOLD_CYC);
  localparam logic [CW-1:0] STEP_LIM = CW'(STEP_CYC);
  localparam logic [CW-1:0] T2_LIM   = CW'(T2_CYC);

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_WAIT,
    ST_RUN
  } prs_dev_st_t;

  typedef enum logic [1:0] {
    HV_OFF,
    HV_CORE,
    HV_ALL
  } prs_hv_st_t;

  typedef struct packed {
    prs_dev_st_t              st;
    prs_hv_st_t               hv_st;
    logic [CW-1:0]            hold_cnt;
    logic [CW-1:0]            step_cnt;
    logic [CW-1:0]            flt_cnt;
    logic                     req_d;
    logic                     rst_n;
    logic                     flt_n;
    logic                     sel_main;
    logic                     core_en;
    logic                     hv_en;
    logic                     lv_en;
    logic [prs_pkg::NDOM-1:0] ok;
    logic                     early;
  } prs_dev_s_t;

  prs_dev_s_t s_r;
  prs_dev_s_t s_nxt;

  // Next battery selection: a lone battery wins, else hysteresis on main.
  function automatic logic pick_main(
    input logic on_main,
    input logic main_ok,
    input logic backup_ok,
    input logic locked,
    input logic below_lo,
    input logic above_hi
  );
    if (!main_ok) begin
      pick_main = 1'b0;
    end else if (!backup_ok || locked) begin
      pick_main = 1'b1;
    end else if (on_main) begin
      pick_main = !below_lo;
    end else begin
      pick_main = above_hi;
    end
  endfunction : pick_main

  always_comb begin
    s_nxt = s_r;
    s_nxt.req_d = link.reset_request_in_n;

    // Reset output sequencing.
    case (s_r.st)
      ST_HOLD: begin
        s_nxt.rst_n = 1'b0;
        if (!rtc_supply_ok) begin
          s_nxt.hold_cnt = '0;
        end else if (s_r.hold_cnt != HOLD_LIM) begin
          s_nxt.hold_cnt = prs_pkg::cnt_step(s_r.hold_cnt, HOLD_LIM);
        end else if (link.reset_request_in_n) begin
          s_nxt.rst_n = 1'b1;
          s_nxt.st    = ST_RUN;
        end else begin
          s_nxt.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // The hold is over; the release waits for the request to end.
        s_nxt.rst_n = 1'b0;
        if (!rtc_supply_ok) begin
          s_nxt.hold_cnt = '0;
          s_nxt.st       = ST_HOLD;
        end else if (link.reset_request_in_n) begin
          s_nxt.rst_n = 1'b1;
          s_nxt.st    = ST_RUN;
        end
      end
      ST_RUN: begin
        // The low-voltage enable never disturbs a released reset.
        if (!rtc_supply_ok || !link.reset_request_in_n) begin
          s_nxt.rst_n    = 1'b0;
          s_nxt.hold_cnt = '0;
          s_nxt.st       = ST_HOLD;
        end
      end
      default: begin
        s_nxt.rst_n    = 1'b0;
        s_nxt.hold_cnt = '0;
        s_nxt.st       = ST_HOLD;
      end
    endcase

    // High-voltage supplies: core/IO first, the rest optionally later.
    s_nxt.core_en = link.high_voltage_domain_enable;
    case (s_r.hv_st)
      HV_OFF, HV_CORE: begin
        if (!link.high_voltage_domain_enable) begin
          s_nxt.step_cnt = '0;
          s_nxt.hv_en    = 1'b0;
          s_nxt.hv_st    = HV_OFF;
        end else if (!hv_delay_on || s_r.step_cnt == STEP_LIM) begin
          s_nxt.hv_en = 1'b1;
          s_nxt.hv_st = HV_ALL;
        end else begin
          s_nxt.step_cnt = prs_pkg::cnt_step(s_r.step_cnt, STEP_LIM);
          s_nxt.hv_st    = HV_CORE;
        end
      end
      HV_ALL: begin
        if (!link.high_voltage_domain_enable) begin
          s_nxt.step_cnt = '0;
          s_nxt.hv_en    = 1'b0;
          s_nxt.hv_st    = HV_OFF;
        end
      end
      default: begin
        s_nxt.step_cnt = '0;
        s_nxt.hv_en    = 1'b0;
        s_nxt.hv_st    = HV_OFF;
      end
    endcase

    // Low-voltage regulators by pin or register bit.
    s_nxt.lv_en = link.low_voltage_domain_enable | lv_enable_sw;

    // A flag reads good only for an enabled, settled regulator.
    s_nxt.ok = {s_r.lv_en, s_r.hv_en, s_r.core_en} & reg_settled;

    // Battery switch with hysteresis and disable bit.
    s_nxt.sel_main = pick_main(s_r.sel_main, main_present, backup_present,
                               no_backup_battery, main_below_lo,
                               main_above_hi);

    // The fault threshold sits above the switchover level.
    s_nxt.flt_n = main_present & ~main_below_fault & ~main_below_lo;

    // Flag a reset request made too soon after fault release.
    if (!s_r.flt_n) begin
      s_nxt.flt_cnt = '0;
    end else begin
      s_nxt.flt_cnt = prs_pkg::cnt_step(s_r.flt_cnt, T2_LIM);
    end
    s_nxt.early = s_r.req_d & ~link.reset_request_in_n & s_r.flt_n &
                  (s_r.flt_cnt != T2_LIM);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_r          <= '0;
      s_r.st       <= ST_HOLD;
      s_r.hv_st    <= HV_OFF;
      s_r.rst_n    <= prs_pkg::RST_OUT_N_RST;
      s_r.flt_n    <= prs_pkg::FLT_N_RST;
      s_r.req_d    <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.reset_out_n         = s_r.rst_n;
  assign link.main_supply_fault_n = s_r.flt_n;
  assign link.domain_ok           = s_r.ok;
  assign rtc_from_main            = s_r.sel_main;
  assign core_io_regulator_en     = s_r.core_en;
  assign hv_other_en              = s_r.hv_en;
  assign lv_regulators_en         = s_r.lv_en;
  assign early_request            = s_r.early;

endmodule : prs_device

// ===== prs_pkg.sv
// Package of constants and helpers for the reset and power sequencer.
// Summary of operation
// - Hold reset 50 ms after RTC supply.
// - High-voltage enable waits for reset and fault release.
// - High-voltage enable starts core/IO first, rest later.
// - Processor counts 125 ms, then low-voltage enable.
// - Low-voltage enable by pin or register bit.
// - Processor waits, then checks domain flags good.
// - Per-domain regulating flag, valid once settled.
// - Reset request asserts reset, released 50 ms on.
// - Reset stays low about 50 ms.
// - High-voltage enable about 10 ms after reset release.
// - Fault release to reset request 100 us.
// - High-voltage enable to low-voltage enable 125 ms.
// - Switch picks lone battery, main above 3.1 V.
// - Backup below 2.9 V, main again above 3.1 V.
// - Fault warning comes before switchover to backup.
// - No-backup bit disables the battery switch.
// - Fault low when main absent or below threshold.
package prs_pkg;

  localparam int CLK_MHZ      = 125;
  localparam int CNT_W        = 24;

  localparam int RST_HOLD_MS  = 50;
  localparam int T2_US        = 100;
  localparam int T3_MS        = 10;
  localparam int HV_WAIT_MS   = 125;
  localparam int LV_WAIT_MS   = 125;
  localparam int HV_STEP_MS   = 1;

  localparam int RST_HOLD_CYC = RST_HOLD_MS * 1000 * CLK_MHZ;
  localparam int T2_CYC       = T2_US * CLK_MHZ;
  localparam int T3_CYC       = T3_MS * 1000 * CLK_MHZ;
  localparam int HV_WAIT_CYC  = HV_WAIT_MS * 1000 * CLK_MHZ;
  localparam int LV_WAIT_CYC  = LV_WAIT_MS * 1000 * CLK_MHZ;
  localparam int HV_STEP_CYC  = HV_STEP_MS * 1000 * CLK_MHZ;
  localparam int REQ_PULSE_CYC = 8;

  localparam int NDOM         = 3;
  localparam int DOM_CORE     = 0;
  localparam int DOM_HV       = 1;
  localparam int DOM_LV       = 2;

  localparam logic RST_OUT_N_RST = 1'b0;
  localparam logic FLT_N_RST     = 1'b0;

  // Saturating up-count toward a limit.
  function automatic logic [CNT_W-1:0] cnt_step(
    input logic [CNT_W-1:0] cnt,
    input logic [CNT_W-1:0] lim
  );
    cnt_step = (cnt == lim) ? cnt : cnt + 24'h000001;
  endfunction : cnt_step

endpackage : prs_pkg

// ===== prs_link_if.sv
// Interface joining the sequencer device and the processor end.
`timescale 1ns/1ps
interface prs_link_if;

  logic                      reset_out_n;
  logic                      main_supply_fault_n;
  logic                      high_voltage_domain_enable;
  logic                      low_voltage_domain_enable;
  logic                      reset_request_in_n;
  logic [prs_pkg::NDOM-1:0]  domain_ok;

  modport dev (
    output reset_out_n,
    output main_supply_fault_n,
    output domain_ok,
    input  high_voltage_domain_enable,
    input  low_voltage_domain_enable,
    input  reset_request_in_n
  );

  modport host (
    input  reset_out_n,
    input  main_supply_fault_n,
    input  domain_ok,
    output high_voltage_domain_enable,
    output low_voltage_domain_enable,
    output reset_request_in_n
  );

endinterface : prs_link_if

// ===== prs_host.sv
// Processor end: waits for release, steps enables, checks domain flags.
`timescale 1ns/1ps
module prs_host #(
  parameter int T3_CYC  = prs_pkg::T3_CYC,
  parameter int HV_CYC  = prs_pkg::HV_WAIT_CYC,
  parameter int LV_CYC  = prs_pkg::LV_WAIT_CYC,
  parameter int T2_CYC  = prs_pkg::T2_CYC,
  parameter logic [prs_pkg::NDOM-1:0] DOM_MASK = 3'h7
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Link to the device
  prs_link_if.host  link,
  // User side
  input  wire logic reset_cmd,
  output logic      boot_ok,
  output logic      boot_fail
);

  localparam int CW = prs_pkg::CNT_W;
  localparam logic [CW-1:0] T3_LIM  = CW'(T3_CYC);
  localparam logic [CW-1:0] HV_LIM  = CW'(HV_CYC);
  localparam logic [CW-1:0] LV_LIM  = CW'(LV_CYC);
  localparam logic [CW-1:0] T2_LIM  = CW'(T2_CYC);
  localparam logic [CW-1:0] REQ_LIM = CW'(prs_pkg::REQ_PULSE_CYC - 1);

  typedef enum logic [2:0] {
    H_WAIT,
    H_T3,
    H_HV,
    H_LV,
    H_RUN,
    H_FAIL
  } prs_host_st_t;

  typedef struct packed {
    prs_host_st_t  st;
    logic [CW-1:0] cnt;
    logic [CW-1:0] flt_cnt;
    logic [CW-1:0] req_cnt;
    logic          req_pend;
    logic          req_n;
    logic          hv;
    logic          lv;
    logic          ok;
    logic          fail;
  } prs_host_s_t;

  prs_host_s_t s_r;
  prs_host_s_t s_nxt;

  always_comb begin
    s_nxt = s_r;

    if (!link.main_supply_fault_n) begin
      s_nxt.flt_cnt = '0;
    end else begin
      s_nxt.flt_cnt = prs_pkg::cnt_step(s_r.flt_cnt, T2_LIM);
    end

    // Reset request pulse, held off until the fault has been released long.
    if (reset_cmd) begin
      s_nxt.req_pend = 1'b1;
    end
    if (!s_r.req_n) begin
      if (s_r.req_cnt == REQ_LIM) begin
        s_nxt.req_n = 1'b1;
      end else begin
        s_nxt.req_cnt = prs_pkg::cnt_step(s_r.req_cnt, REQ_LIM);
      end
    end else if (s_r.req_pend && s_r.flt_cnt == T2_LIM) begin
      s_nxt.req_n    = 1'b0;
      s_nxt.req_pend = 1'b0;
      s_nxt.req_cnt  = '0;
    end

    case (s_r.st)
      H_WAIT: begin
        s_nxt.cnt = '0;
        if (link.reset_out_n && link.main_supply_fault_n) begin
          s_nxt.st = H_T3;
        end
      end
      H_T3: begin
        if (!link.main_supply_fault_n) begin
          s_nxt.st = H_WAIT;
        end else if (s_r.cnt == T3_LIM) begin
          s_nxt.hv  = 1'b1;
          s_nxt.cnt = '0;
          s_nxt.st  = H_HV;
        end else begin
          s_nxt.cnt = prs_pkg::cnt_step(s_r.cnt, T3_LIM);
        end
      end
      H_HV: begin
        if (s_r.cnt == HV_LIM) begin
          s_nxt.lv  = 1'b1;
          s_nxt.cnt = '0;
          s_nxt.st  = H_LV;
        end else begin
          s_nxt.cnt = prs_pkg::cnt_step(s_r.cnt, HV_LIM);
        end
      end
      H_LV: begin
        if (s_r.cnt == LV_LIM) begin
          if ((link.domain_ok & DOM_MASK) == DOM_MASK) begin
            s_nxt.ok = 1'b1;
            s_nxt.st = H_RUN;
          end else begin
            s_nxt.fail = 1'b1;
            s_nxt.st   = H_FAIL;
          end
        end else begin
          s_nxt.cnt = prs_pkg::cnt_step(s_r.cnt, LV_LIM);
        end
      end
      H_RUN: begin
      end
      H_FAIL: begin
      end
      default: begin
        s_nxt.st = H_WAIT;
      end
    endcase

    // A reset from the device restarts the whole sequence.
    if (!link.reset_out_n || !s_r.req_n) begin
      s_nxt.st   = H_WAIT;
      s_nxt.hv   = 1'b0;
      s_nxt.lv   = 1'b0;
      s_nxt.ok   = 1'b0;
      s_nxt.fail = 1'b0;
      s_nxt.cnt  = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_r       <= '0;
      s_r.st    <= H_WAIT;
      s_r.req_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.high_voltage_domain_enable = s_r.hv;
  assign link.low_voltage_domain_enable  = s_r.lv;
  assign link.reset_request_in_n         = s_r.req_n;
  assign boot_ok                         = s_r.ok;
  assign boot_fail                       = s_r.fail;

endmodule : prs_host

// ===== prs_link_properties.sv
// Checker of the link between the sequencer device and the processor end.
`timescale 1ns/1ps
module prs_link_checker #(
  parameter int HOLD = 20,
  parameter int T3   = 10,
  parameter int HV   = 20
) (
  // Clock and reset
  input wire logic                     clock,
  input wire logic                     rst,
  // Link signals
  input wire logic                     reset_out_n,
  input wire logic                     main_supply_fault_n,
  input wire logic                     high_voltage_domain_enable,
  input wire logic                     low_voltage_domain_enable,
  input wire logic                     reset_request_in_n,
  input wire logic [prs_pkg::NDOM-1:0] domain_ok,
  // Register-path enable of the low-voltage regulators
  input wire logic                     lv_enable_sw
);
  typedef struct packed {
    logic [23:0] low;
    logic [23:0] up;
    logic [23:0] hv;
  } prs_chk_t;

  prs_chk_t  chk_r;
  prs_chk_t  chk_nxt;
  wire logic hv = high_voltage_domain_enable;
  wire logic lv = low_voltage_domain_enable;
  wire logic lv_any = lv | lv_enable_sw;

  // Saturating run lengths: reset low, both releases high, HV enable high.
  always_comb begin
    chk_nxt = chk_r;
    chk_nxt.low = reset_out_n ? '0 : chk_r.low + 24'(~&chk_r.low);
    chk_nxt.up = (reset_out_n && main_supply_fault_n) ?
                 chk_r.up + 24'(~&chk_r.up) : '0;
    chk_nxt.hv = hv ? chk_r.hv + 24'(~&chk_r.hv) : '0;
    if (rst) begin
      chk_nxt = '0;
    end
  end

  always_ff @(posedge clock) begin
    chk_r <= chk_nxt;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence req_pulse_s;
    !reset_request_in_n [*8] ##1 reset_request_in_n;
  endsequence

  a_req_drops_reset: assert property (
    $fell(reset_request_in_n) |=> !reset_out_n)
    else $error("reset output did not follow the request");
  a_req_pulse_width: assert property (
    $fell(reset_request_in_n) |-> req_pulse_s)
    else $error("reset request pulse has the wrong width");
  a_hold_min_time: assert property (
    $rose(reset_out_n) |-> chk_r.low >= HOLD)
    else $error("reset output released too early");
  a_release_needs_req: assert property (
    $rose(reset_out_n) |-> reset_request_in_n)
    else $error("reset released while request is low");
  a_hv_after_release: assert property (
    $rose(hv) |-> reset_out_n && main_supply_fault_n)
    else $error("HV enable raised before both releases");
  a_hv_wait_time: assert property (
    $rose(hv) |-> chk_r.up >= T3)
    else $error("HV enable raised too soon after release");
  a_lv_after_hv: assert property (
    $rose(lv) |-> hv && chk_r.hv >= HV)
    else $error("LV enable raised too soon after HV enable");
  a_core_ok_cause: assert property (
    domain_ok[0] |-> $past(hv, 2))
    else $error("core flag good without HV enable");
  a_lv_ok_cause: assert property (
    domain_ok[2] |-> $past(lv_any, 2))
    else $error("LV flag good without LV enable");
  a_reset_drops_hv: assert property (
    $fell(reset_out_n) |-> ##[0:3] !hv)
    else $error("HV enable kept through a reset");

endmodule : prs_link_checker

// ===== prs_tb.sv
// Self-checking bench: device and processor ends joined over the link.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module prs_tb;
  localparam int HOLD = 20;
  localparam int STEP = 4;
  localparam int T2   = 6;
  localparam int T3   = 10;
  localparam int HV   = 20;
  localparam int LV   = 20;

  logic        clock, rst, reset_cmd, boot_ok, boot_fail, early2, early_clr;
  logic        rtc_supply_ok, main_present, backup_present, main_above_hi;
  logic        main_below_lo, main_below_fault, no_backup_battery;
  logic        hv_delay_on, lv_enable_sw, rtc_from_main, core_io_regulator_en;
  logic        hv_other_en, lv_regulators_en, early_seen, rtc_main_exp;
  logic [2:0]  reg_settled;
  logic [11:0] obs;
  logic [23:0] head;
  logic [23:0] exp_q[$];
  logic [31:0] seed = 32'h0000B595;
  int          bad_count = 0;
  int          n_checks = 0;

  prs_link_if link ();
  prs_link_if link2 ();

  prs_device #(.HOLD_CYC(HOLD), .STEP_CYC(STEP), .T2_CYC(T2)) prs_device_i (
    .clock, .rst, .link(link.dev), .rtc_supply_ok, .main_present,
    .backup_present, .main_above_hi, .main_below_lo, .main_below_fault,
    .no_backup_battery, .hv_delay_on, .lv_enable_sw, .reg_settled,
    .rtc_from_main, .core_io_regulator_en, .hv_other_en, .lv_regulators_en,
    .early_request());

  // Second device whose processor side is driven directly by the bench.
  prs_device #(.HOLD_CYC(HOLD), .STEP_CYC(STEP), .T2_CYC(T2)) prs_device_i2 (
    .clock, .rst, .link(link2.dev), .rtc_supply_ok, .main_present,
    .backup_present, .main_above_hi, .main_below_lo, .main_below_fault,
    .no_backup_battery, .hv_delay_on, .lv_enable_sw, .reg_settled,
    .rtc_from_main(), .core_io_regulator_en(), .hv_other_en(),
    .lv_regulators_en(), .early_request(early2));

  prs_host #(.T3_CYC(T3), .HV_CYC(HV), .LV_CYC(LV), .T2_CYC(T2)) prs_host_i (
    .clock, .rst, .link(link.host), .reset_cmd, .boot_ok, .boot_fail);

  prs_link_checker #(.HOLD(HOLD), .T3(T3), .HV(HV)) prs_link_checker_i (
    .clock, .rst, .reset_out_n(link.reset_out_n),
    .main_supply_fault_n(link.main_supply_fault_n),
    .high_voltage_domain_enable(link.high_voltage_domain_enable),
    .low_voltage_domain_enable(link.low_voltage_domain_enable),
    .reset_request_in_n(link.reset_request_in_n),
    .domain_ok(link.domain_ok), .lv_enable_sw);

  assign obs = {early_seen, boot_fail, boot_ok, lv_regulators_en, hv_other_en,
                core_io_regulator_en, link.reset_out_n,
                link.main_supply_fault_n, rtc_from_main, link.domain_ok};

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  task note(input logic [11:0] m, input logic [11:0] v);
    exp_q.push_back({m, v});
  endtask : note

  task cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc

  task summarize;
    if (bad_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // The one-cycle pulse of the second device is caught in a sticky flag.
  always @(posedge clock) begin
    if (early_clr) begin
      early_seen <= 1'b0;
    end else if (early2 === 1'b1) begin
      early_seen <= 1'b1;
    end
  end

  always @(negedge clock) begin
    #2;
    if (exp_q.size() > 0) begin
      head = exp_q.pop_front();
      `CHK(obs & head[23:12], head[11:0])
    end
  end

  initial begin
    repeat (5000) @(posedge clock);
    bad_count++;
    summarize();
  end

  initial begin
    {rst, backup_present, hv_delay_on} = 3'h7;
    {reset_cmd, rtc_supply_ok, main_present, main_above_hi} = 4'h0;
    {main_below_lo, main_below_fault, no_backup_battery} = 3'h0;
    {lv_enable_sw, early_clr} = 2'h1;
    reg_settled = 3'h7;
    link2.high_voltage_domain_enable = 1'b0;
    link2.low_voltage_domain_enable = 1'b0;
    link2.reset_request_in_n = 1'b1;
    cyc(16);
    rst = 1'b0;
    early_clr = 1'b0;
    rtc_supply_ok = 1'b1;
    cyc(HOLD);
    note(12'h038, 12'h000);
    for (int i = 0; i < 8 && !link.reset_out_n; i++) cyc(1);
    note(12'h020, 12'h020);
    cyc(T3 + 10);
    note(12'h1C0, 12'h000);
    {main_present, main_above_hi} = 2'h3;
    cyc(2);
    note(12'h018, 12'h018);
    for (int i = 0; i < T3 + 8 && !core_io_regulator_en; i++) cyc(1);
    note(12'h0C0, 12'h040);
    for (int i = 0; i < 200 && !(boot_ok | boot_fail); i++) cyc(1);
    note(12'h7C7, 12'h3C7);
    // LV domain never settles and the HV supplies come up together.
    {reg_settled, hv_delay_on, reset_cmd} = 5'h0D;
    cyc(1);
    reset_cmd = 1'b0;
    for (int i = 0; i < 40 && link.reset_out_n; i++) cyc(1);
    lv_enable_sw = 1'b1;
    cyc(2);
    note(12'h320, 12'h100);
    lv_enable_sw = 1'b0;
    for (int i = 0; i < 300 && !(boot_ok | boot_fail); i++) cyc(1);
    note(12'h6E7, 12'h4E3);
    main_below_fault = 1'b1;
    cyc(3);
    main_below_fault = 1'b0;
    cyc(2);
    for (int k = 0; k < 2; k++) begin
      link2.reset_request_in_n = 1'b0;
      cyc(8);
      link2.reset_request_in_n = 1'b1;
      cyc(2);
      note(12'h800, k ? 12'h000 : 12'h800);
      cyc(T2 + 4);
      early_clr = 1'b1;
      cyc(1);
      early_clr = 1'b0;
    end
    rtc_main_exp = 1'b1;
    for (int i = 0; i < 60; i++) begin
      seed = xs(seed);
      main_present = |seed[1:0];
      backup_present = seed[2];
      main_below_lo = &seed[4:3];
      main_above_hi = !main_below_lo && seed[5];
      main_below_fault = seed[6];
      no_backup_battery = &seed[8:7];
      cyc(1);
      rtc_main_exp = !main_present ? 1'b0 :
        (no_backup_battery || !backup_present) ? 1'b1 :
        rtc_main_exp ? !main_below_lo : main_above_hi;
      note(12'h018, {7'h00, main_present && !main_below_fault &&
           !main_below_lo, rtc_main_exp, 3'h0});
    end
    cyc(2);
    summarize();
  end

endmodule : prs_tb
